// file: hdl/bus_cycle_pkg.sv
// Constants, types and carriers for the local bus cycle sequencer.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
//
// Notes on behaviour
// - Each bus cycle spans at least two clocks
// - Strobe in first clock with address valid
// - Ready sampled from second clock end onward
// - Parity result shown one clock after read
// - Burst items arrive every clock after first
// - Writes never burst on full width bus
// - Last-transfer high in second clock offers burst; code also drives it high for non-final items of unburstable cycles
// - Burst stays in one 16-byte block
// - Multi-item reads may burst, only needed bytes
// - Unburstable cycles treat burst ready as ready
// - Both readies active means non-burst completion
// - Last-transfer low in final data cycle, held while idle
// - Item count from size, alignment, cacheable
// - Cut burst keeps order, last stays high
// - Non-burst transfer is chain of single cycles
// - Strobe only for first item of a burst
// - Burst order follows starting word exclusive-or
// - Cut burst restarts strobe immediately
package bus_cycle_pkg;

  // -------------------------------------------------------------
  // Sizes and geometry
  // -------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WORD_ADDR_W = 30;
  localparam int unsigned LINE_ITEMS = 4;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [2:0] SIZE_1B = 3'h0;
  localparam logic [2:0] SIZE_2B = 3'h1;
  localparam logic [2:0] SIZE_4B = 3'h2;
  localparam logic [2:0] SIZE_8B = 3'h3;
  localparam logic [2:0] SIZE_16B = 3'h4;
  localparam logic [2:0] ITEMS_FILL = 3'h4;
  localparam logic [3:0] LANES_ALL_N = 4'h0;
  localparam logic [3:0] LANES_NONE_N = 4'hf;

  // -------------------------------------------------------------
  // Reset values of the bus outputs
  // -------------------------------------------------------------
  localparam logic STROBE_IDLE_N = 1'b1;
  localparam logic LAST_IDLE_N = 1'b0;
  localparam logic PARITY_IDLE_N = 1'b1;

  // -------------------------------------------------------------
  // Carriers
  // -------------------------------------------------------------
  typedef struct packed {
    logic [31:0] addr;
    logic [2:0] size;
    logic write;
    logic mem_io;
    logic data_code;
    logic burstable;
    logic fill_ok;
    logic [31:0] wdata;
  } req_s;

  typedef struct packed {
    logic [31:0] data;
    logic [29:0] word_addr;
    logic width_byte;
    logic width_half;
    logic fill;
  } rd_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FIRST,
    ST_SECOND
  } bus_state_e;

endpackage

// file: hdl/read_fifo.sv
// Read data buffer between bus sequencer and internal consumer.
// Assumes the writer checks level before committing to pushes.
`timescale 1ns/1ps
module read_fifo #(
  parameter int unsigned WIDTH = 64,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned LW = $clog2(DEPTH + 1)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [LW-1:0] level
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [LW-1:0] count_ff;
  logic [LW-1:0] nxt_count;
  logic valid_ff;
  logic push;
  logic pop;

  assign in_ready = count_ff < LW'(DEPTH);
  // Valid kept in its own flop so the output leaves a register
  assign out_valid = valid_ff;
  assign out_data = mem_ff[rd_ptr_ff];
  assign level = count_ff;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_comb begin
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = count_ff + LW'(1);
    end else if (pop && !push) begin
      nxt_count = count_ff - LW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      valid_ff <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_ff <= bump(wr_ptr_ff);
      end
      if (pop) begin
        rd_ptr_ff <= bump(rd_ptr_ff);
      end
      count_ff <= nxt_count;
      valid_ff <= nxt_count != '0;
    end
  end

endmodule

// file: hdl/parity_check.sv
// Even byte parity checker for read data taken off the bus.
// Assumes one parity bit per byte lane, sampled with the data.
`timescale 1ns/1ps
module parity_check
  import bus_cycle_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic strobe,
  input wire logic [31:0] data,
  input wire logic [3:0] par,
  output logic parity_error_n
);
  logic bad;

  always_comb begin
    bad = 1'b0;
    for (int i = 0; i < 4; i++) begin
      bad = bad | (^{data[8*i +: 8], par[i]});
    end
  end

  // Result appears the clock after the read item was strobed in
  always_ff @(posedge clk) begin
    if (rst) begin
      parity_error_n <= PARITY_IDLE_N;
    end else begin
      parity_error_n <= !(strobe && bad);
    end
  end

endmodule

// file: hdl/bus_cycle_unit.sv
// Local bus cycle sequencer: single, multiple and burst data cycles.
// Assumes system logic drives ready, burst ready, cacheable and widths
// synchronously, and an internal requester holding req until taken.
`timescale 1ns/1ps
module bus_cycle_unit
  import bus_cycle_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire req_s req,
  output logic rd_valid,
  input wire logic rd_ready,
  output rd_s rd,
  output logic [29:0] address,
  output logic [3:0] byte_lane_enables_n,
  output logic mem_io,
  output logic data_code,
  output logic write,
  output logic address_strobe_n,
  output logic last_transfer_n,
  input wire logic ready_n,
  input wire logic burst_ready_n,
  input wire logic cacheable_n,
  input wire logic width_byte_n,
  input wire logic width_half_n,
  input wire logic [31:0] data_in,
  input wire logic [3:0] data_par_in,
  output logic [31:0] data_out,
  output logic data_oe,
  output logic parity_error_n
);
  localparam int unsigned LW = $clog2(DEPTH + 1);
  localparam logic [LW-1:0] ROOM = LW'(DEPTH - LINE_ITEMS);

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  function automatic logic [2:0] size_bytes(input logic [2:0] s);
    unique case (s)
      SIZE_1B: size_bytes = 3'h1;
      SIZE_2B: size_bytes = 3'h2;
      default: size_bytes = 3'h4;
    endcase
  endfunction

  // Operand of up to four bytes that spills into the next word
  function automatic logic crosses(input logic [1:0] off, input logic [2:0] s);
    crosses = (s <= SIZE_4B) && ({1'b0, off} + size_bytes(s) > 3'h4);
  endfunction

  function automatic logic [2:0] items_of(input logic [1:0] off, input logic [2:0] s);
    if (s == SIZE_16B) begin
      items_of = 3'h4;
    end else if (s == SIZE_8B) begin
      items_of = 3'h2;
    end else begin
      items_of = crosses(off, s) ? 3'h2 : 3'h1;
    end
  endfunction

  // Lanes of one part; high-order part goes first on a split
  function automatic logic [3:0] lanes_n(input logic [1:0] off, input logic [2:0] s, input logic hi);
    logic [7:0] m;
    m = 8'h0;
    if (s > SIZE_4B) begin
      lanes_n = LANES_ALL_N;
    end else begin
      m = 8'((9'h1 << size_bytes(s)) - 9'h1) << off;
      lanes_n = hi ? ~m[7:4] : ~m[3:0];
    end
  endfunction

  // Fixed order inside the 16-byte block from the starting word
  function automatic logic [1:0] order_word(input logic [1:0] start, input logic [1:0] idx);
    order_word = start ^ idx;
  endfunction

  // -------------------------------------------------------------
  // State
  // -------------------------------------------------------------
  bus_state_e state_ff;
  bus_state_e nxt_state;
  req_s req_ff;
  logic [29:0] base_ff;
  logic [1:0] idx_ff;
  logic [2:0] left_ff;
  logic first_ff;
  logic cross_ff;
  logic fill_ff;
  logic ken_q_ff;
  logic wb_q_ff;
  logic wh_q_ff;
  logic req_ready_ff;
  logic [29:0] address_ff;
  logic [3:0] lanes_ff;
  logic strobe_n_ff;
  logic last_n_ff;
  logic [31:0] dout_ff;
  logic oe_ff;

  logic accept;
  logic take;
  logic by_burst;
  logic go_fill;
  logic [2:0] nxt_left;
  logic burst_ok;
  logic [1:0] nxt_idx;
  logic [29:0] nxt_address;
  logic [3:0] nxt_lanes;
  logic nxt_last_n;
  logic fill_possible;
  logic fifo_in_ready;
  logic [LW-1:0] fifo_level;
  rd_s push_data;
  logic [2:0] items_new;

  assign accept = state_ff == ST_IDLE && req_valid && req_ready_ff;
  // Ready is not looked at in the strobe clock
  assign take = state_ff == ST_SECOND && (!ready_n || !burst_ready_n);
  assign fill_possible = !req_ff.write && req_ff.fill_ok && !cross_ff;
  // Fill decided on cacheable as it stood the clock before ready
  assign go_fill = take && first_ff && fill_possible && !ken_q_ff;
  // Burst only for multi-item reads of a burstable kind, never writes
  assign burst_ok = !req_ff.write && req_ff.burstable && !cross_ff && (left_ff > 3'h1 || go_fill);
  // Ready wins over burst ready; unburstable cycles end on either
  assign by_burst = ready_n && !burst_ready_n && burst_ok;
  assign items_new = items_of(req.addr[1:0], req.size);

  always_comb begin
    nxt_left = left_ff;
    if (go_fill && left_ff < ITEMS_FILL) begin
      nxt_left = ITEMS_FILL - 3'h1;
    end else if (take) begin
      nxt_left = left_ff - 3'h1;
    end
  end

  // -------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (accept) begin
          nxt_state = ST_FIRST;
        end
      end
      ST_FIRST: begin
        nxt_state = ST_SECOND;
      end
      ST_SECOND: begin
        if (take) begin
          if (nxt_left == 3'h0) begin
            nxt_state = ST_IDLE;
          end else if (by_burst) begin
            nxt_state = ST_SECOND;
          end else begin
            nxt_state = ST_FIRST;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ken_q_ff <= 1'b1;
      wb_q_ff <= 1'b1;
      wh_q_ff <= 1'b1;
    end else begin
      ken_q_ff <= cacheable_n;
      wb_q_ff <= width_byte_n;
      wh_q_ff <= width_half_n;
    end
  end

  // -------------------------------------------------------------
  // Transfer bookkeeping
  // -------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      req_ff <= '0;
      base_ff <= '0;
      idx_ff <= '0;
      left_ff <= '0;
      first_ff <= 1'b0;
      cross_ff <= 1'b0;
      fill_ff <= 1'b0;
    end else if (accept) begin
      req_ff <= req;
      // Write bytes rotated onto their lanes for either part
      req_ff.wdata <= (req.wdata << {req.addr[1:0], 3'h0}) | (req.wdata >> {~req.addr[1:0] + 2'h1, 3'h0});
      base_ff <= req.addr[31:2];
      idx_ff <= '0;
      left_ff <= items_new;
      first_ff <= 1'b1;
      cross_ff <= crosses(req.addr[1:0], req.size);
      fill_ff <= 1'b0;
    end else if (take) begin
      idx_ff <= nxt_idx;
      left_ff <= nxt_left;
      first_ff <= 1'b0;
      if (go_fill) begin
        fill_ff <= 1'b1;
      end
    end
  end

  assign nxt_idx = idx_ff + 2'h1;

  // Next item address: split operands step down a word, others follow order
  always_comb begin
    nxt_address = address_ff;
    nxt_lanes = lanes_ff;
    if (accept) begin
      if (crosses(req.addr[1:0], req.size)) begin
        nxt_address = req.addr[31:2] + 30'h1;
      end else begin
        nxt_address = req.addr[31:2];
      end
      nxt_lanes = lanes_n(req.addr[1:0], req.size, crosses(req.addr[1:0], req.size));
    end else if (take && nxt_left != 3'h0) begin
      if (cross_ff) begin
        nxt_address = base_ff;
        nxt_lanes = lanes_n(req_ff.addr[1:0], req_ff.size, 1'b0);
      end else begin
        // Upper bits and cycle definition held across the block
        nxt_address = {base_ff[29:2], order_word(base_ff[1:0], nxt_idx)};
        nxt_lanes = LANES_ALL_N;
      end
    end
  end

  // Low when the coming data cycle is known to be the final one; held while idle
  always_comb begin
    nxt_last_n = last_n_ff;
    if (nxt_state == ST_FIRST) begin
      nxt_last_n = !(accept ? items_new == 3'h1 : nxt_left == 3'h1);
    end else if (nxt_state == ST_SECOND) begin
      nxt_last_n = !((take ? nxt_left : left_ff) == 3'h1 && !(first_ff && !take && fill_possible && !cacheable_n));
    end
  end

  // -------------------------------------------------------------
  // Bus outputs
  // -------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      strobe_n_ff <= STROBE_IDLE_N;
      last_n_ff <= LAST_IDLE_N;
      address_ff <= '0;
      lanes_ff <= LANES_NONE_N;
    end else begin
      strobe_n_ff <= nxt_state != ST_FIRST;
      last_n_ff <= nxt_last_n;
      address_ff <= nxt_address;
      lanes_ff <= nxt_lanes;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dout_ff <= '0;
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= nxt_state != ST_IDLE && (accept ? req.write : req_ff.write);
      if (accept) begin
        dout_ff <= (req.wdata << {req.addr[1:0], 3'h0}) | (req.wdata >> {~req.addr[1:0] + 2'h1, 3'h0});
      end
    end
  end

  // Room for a whole line of reads, counting the item pushed this clock
  always_ff @(posedge clk) begin
    if (rst) begin
      req_ready_ff <= 1'b0;
    end else begin
      req_ready_ff <= nxt_state == ST_IDLE && !accept && fifo_level + LW'(take && !req_ff.write) <= ROOM;
    end
  end

  assign req_ready = req_ready_ff;
  assign address = address_ff;
  assign byte_lane_enables_n = lanes_ff;
  assign mem_io = req_ff.mem_io;
  assign data_code = req_ff.data_code;
  assign write = req_ff.write;
  assign address_strobe_n = strobe_n_ff;
  assign last_transfer_n = last_n_ff;
  assign data_out = dout_ff;
  assign data_oe = oe_ff;

  // -------------------------------------------------------------
  // Read path
  // -------------------------------------------------------------
  always_comb begin
    push_data.data = data_in;
    push_data.word_addr = address_ff;
    push_data.width_byte = !wb_q_ff;
    push_data.width_half = !wh_q_ff;
    push_data.fill = fill_ff || go_fill;
  end

  read_fifo #(
    .WIDTH($bits(rd_s)),
    .DEPTH(DEPTH),
    .LW(LW)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(take && !req_ff.write && fifo_in_ready),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd),
    .level(fifo_level)
  );

  parity_check u_parity (
    .clk(clk),
    .rst(rst),
    .strobe(take && !req_ff.write),
    .data(data_in),
    .par(data_par_in),
    .parity_error_n(parity_error_n)
  );

endmodule

// file: verif/bus_cycle_chk.sv
// Port checker for the bus cycle sequencer.
// Assumes the bind below onto bus_cycle_unit.
`timescale 1ns/1ps
module bus_cycle_chk
  import bus_cycle_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [29:0] address,
  input wire logic mem_io,
  input wire logic data_code,
  input wire logic write,
  input wire logic address_strobe_n,
  input wire logic last_transfer_n,
  input wire logic ready_n,
  input wire logic burst_ready_n,
  input wire logic data_oe,
  input wire logic parity_error_n
);
  // ---------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_STROBE_ONE: assert property (!address_strobe_n |=> address_strobe_n)
    else $error("strobe held past first clock");
  AST_REQ_STROBE: assert property (req_valid && req_ready |=> !address_strobe_n)
    else $error("no strobe after request taken");
  AST_FIRST_IGNORED: assert property (!address_strobe_n |=> !req_ready && address_strobe_n && parity_error_n)
    else $error("cycle ended at first clock");
  AST_PARITY: assert property (!parity_error_n |-> !$past(ready_n) || !$past(burst_ready_n))
    else $error("parity flag without prior ready");
  AST_BURST_STABLE: assert property (address_strobe_n && last_transfer_n && ready_n && !burst_ready_n
    |=> $stable({address[29:2], mem_io, data_code, write}))
    else $error("burst left its block or definition");
  AST_FINAL_IDLE: assert property (address_strobe_n && !last_transfer_n && !(ready_n && burst_ready_n)
    |=> address_strobe_n [*2])
    else $error("activity after final item");
  AST_RESTART: assert property (address_strobe_n && last_transfer_n && !ready_n |=> !address_strobe_n)
    else $error("no new strobe after cut");
  AST_RESET_IDLE: assert property ($fell(rst) |-> address_strobe_n == STROBE_IDLE_N && !req_ready
    && !data_oe && parity_error_n == PARITY_IDLE_N && last_transfer_n == LAST_IDLE_N)
    else $error("not idle after reset");
  COV_BURST: cover property (address_strobe_n && last_transfer_n && !burst_ready_n && ready_n);
  COV_CUT: cover property (address_strobe_n && last_transfer_n && !ready_n);
  COV_PERR: cover property (!parity_error_n);
endmodule

bind bus_cycle_unit bus_cycle_chk port_chk (.clk, .rst, .req_valid, .req_ready, .address, .mem_io,
  .data_code, .write, .address_strobe_n, .last_transfer_n, .ready_n, .burst_ready_n, .data_oe,
  .parity_error_n);

// file: verif/mem_model.sv
// Memory controller model on the far side of the bus.
// Assumes the bench sets waits, mode, cut and ken between transfers.
`timescale 1ns/1ps
module mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic address_strobe_n,
  input wire logic last_transfer_n,
  input wire logic [29:0] address,
  input wire logic [3:0] waits,
  input wire logic [1:0] mode,
  input wire logic [2:0] cut,
  input wire logic ken,
  input wire logic bad_par,
  output logic ready_n,
  output logic burst_ready_n,
  output logic cacheable_n,
  output logic [31:0] data_in,
  output logic [3:0] data_par_in
);
  logic act;
  logic [3:0] cnt;
  logic [2:0] n;
  logic [31:0] pat;
  logic ack;
  // Mode 0 ready, 1 burst ready, 2 both at once
  assign pat = {address, 2'h0} ^ 32'hc3a5_0f1e;
  assign ack = !ready_n || !burst_ready_n;
  assign data_in = ack ? pat : ~pat;
  assign data_par_in = {^pat[31:24], ^pat[23:16], ^pat[15:8], ^pat[7:0] ^ bad_par};
  assign cacheable_n = !ken;
  always @(posedge clk) begin
    if (rst) begin
      act = 1'b0;
      cnt = 4'h0;
      n = 3'h0;
    end else if (!address_strobe_n) begin
      act = 1'b1;
      cnt = waits;
    end else if (ack) begin
      act = ready_n && last_transfer_n;
      n = last_transfer_n ? n + 3'h1 : 3'h0;
      cnt = waits;
    end else if (cnt != 4'h0) begin
      cnt = cnt - 4'h1;
    end
    ready_n <= !(act && cnt == 4'h0 && (mode != 2'h1 || n == cut));
    burst_ready_n <= !(act && cnt == 4'h0 && mode != 2'h0 && n != cut);
  end
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the bus cycle sequencer.
// Assumes mem_model on the bus side and the bound checker.
`timescale 1ns/1ps
module tb_top
  import bus_cycle_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic rd_ready = 1'b1;
  logic ken = 1'b0;
  logic bad_par = 1'b0;
  logic width_byte_n = 1'b1;
  logic width_half_n = 1'b1;
  logic [3:0] waits = 4'h0;
  logic [1:0] mode = 2'h0;
  logic [2:0] cut = 3'h7;
  req_s req = '0;
  rd_s rd;
  logic req_ready, rd_valid, mem_io, data_code, write, address_strobe_n, last_transfer_n;
  logic ready_n, burst_ready_n, cacheable_n, data_oe, parity_error_n;
  logic [29:0] address;
  logic [3:0] byte_lane_enables_n, data_par_in;
  logic [31:0] data_in, data_out, wcap;
  logic [6:0] dcap;
  logic [29:0] exp_q[$];
  int n_errors = 0, n_tests = 0, n_strobe, n_item, n_perr, cycles = 0;

  always #5 clk = ~clk;

  bus_cycle_unit #(.DEPTH(16)) dut (.clk, .rst, .req_valid, .req_ready, .req, .rd_valid, .rd_ready, .rd,
    .address, .byte_lane_enables_n, .mem_io, .data_code, .write, .address_strobe_n, .last_transfer_n,
    .ready_n, .burst_ready_n, .cacheable_n, .width_byte_n, .width_half_n, .data_in,
    .data_par_in, .data_out, .data_oe, .parity_error_n);
  mem_model mem (.clk, .rst, .address_strobe_n, .last_transfer_n, .address, .waits, .mode, .cut, .ken,
    .bad_par, .ready_n, .burst_ready_n, .cacheable_n, .data_in, .data_par_in);

  // ---------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------
  task complete_run;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] pat(input logic [29:0] w);
    return {w, 2'h0} ^ 32'hc3a5_0f1e;
  endfunction
  always @(posedge clk) begin
    cycles++;
    if (!address_strobe_n) n_strobe++;
    if (!parity_error_n) n_perr++;
    if (data_oe) wcap = data_out;
    if (!address_strobe_n) dcap = {write, mem_io, data_code, byte_lane_enables_n};
    if (rd_valid === 1'b1 && rd_ready) begin
      n_item++;
      chk({2'h0, rd.word_addr}, {2'h0, exp_q.pop_front()});
      chk(rd.data, pat(rd.word_addr));
      chk({29'h0, rd.width_byte, rd.width_half, rd.fill}, {29'h0, !width_byte_n, !width_half_n, ken});
    end
    if (cycles == 2000) begin
      n_errors++;
      complete_run;
    end
  end
  task cfg(input logic [3:0] w, input logic [1:0] m, input logic [2:0] c, input logic k);
    @(negedge clk);
    waits = w;
    mode = m;
    cut = c;
    ken = k;
    bad_par = 1'b0;
    width_byte_n = 1'b1;
    width_half_n = 1'b1;
    n_strobe = 0;
    n_item = 0;
    n_perr = 0;
  endtask
  task go(input logic [31:0] a, input logic [2:0] s, input logic w, b, f, hold);
    @(negedge clk);
    req = '{a, s, w, 1'b1, 1'b0, b, f, 32'h1234_5678};
    req_valid = 1'b1;
    do @(posedge clk); while (req_ready !== 1'b1);
    @(negedge clk);
    req_valid = 1'b0;
    if (hold) do @(posedge clk); while (req_ready !== 1'b1);
  endtask
  task fin(input int s, input int i);
    for (int k = 0; k < 40 && exp_q.size() != 0; k++) @(posedge clk);
    @(posedge clk);
    chk(n_strobe, s);
    chk(n_item, i);
    $display("test ended at %0t", $time);
  endtask

  // ---------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------
  task t_single;
    cfg(0, 0, 7, 0);
    bad_par = 1'b1;
    width_byte_n = 1'b0;
    exp_q = '{30'h43};
    go(32'h10c, SIZE_4B, 1'b0, 1'b1, 1'b0, 1'b1);
    fin(1, 1);
    chk(n_perr, 1);
  endtask
  task t_wait;
    cfg(3, 0, 7, 0);
    width_half_n = 1'b0;
    exp_q = '{30'h40};
    go(32'h100, SIZE_2B, 1'b0, 1'b1, 1'b0, 1'b1);
    fin(1, 1);
    chk({25'h0, dcap}, 32'h2c);
    chk(n_perr, 0);
  endtask
  task t_burst;
    cfg(0, 1, 7, 0);
    exp_q = '{30'h41, 30'h40, 30'h43, 30'h42};
    go(32'h104, SIZE_16B, 1'b0, 1'b1, 1'b1, 1'b1);
    fin(1, 4);
  endtask
  task t_cut;
    cfg(0, 1, 1, 0);
    exp_q = '{30'h41, 30'h40, 30'h43, 30'h42};
    go(32'h104, SIZE_16B, 1'b0, 1'b1, 1'b1, 1'b1);
    fin(2, 4);
  endtask
  task t_both;
    cfg(0, 2, 7, 0);
    exp_q = '{30'h42, 30'h43};
    go(32'h108, SIZE_8B, 1'b0, 1'b1, 1'b0, 1'b1);
    fin(2, 2);
  endtask
  task t_unburst;
    cfg(0, 1, 7, 0);
    exp_q = '{30'h40, 30'h41};
    go(32'h100, SIZE_8B, 1'b0, 1'b0, 1'b0, 1'b1);
    fin(2, 2);
  endtask
  task t_write;
    cfg(0, 1, 7, 0);
    go(32'h200, SIZE_4B, 1'b1, 1'b1, 1'b0, 1'b1);
    fin(1, 0);
    chk(wcap, 32'h1234_5678);
    chk({25'h0, dcap}, 32'h60);
  endtask
  task t_fill;
    cfg(0, 0, 7, 1);
    exp_q = '{30'h42, 30'h43, 30'h40, 30'h41};
    go(32'h108, SIZE_4B, 1'b0, 1'b1, 1'b1, 1'b1);
    fin(4, 4);
  endtask
  task t_fifo;
    cfg(1, 1, 7, 0);
    rd_ready = 1'b0;
    for (int i = 0; i < 16; i++) exp_q.push_back(30'h40 + 30'(i));
    for (int i = 0; i < 4; i++) go(32'h100 + 32'(i * 16), SIZE_16B, 1'b0, 1'b1, 1'b1, i < 3);
    repeat (16) @(posedge clk);
    chk(req_ready, 0);
    @(negedge clk);
    rd_ready = 1'b1;
    fin(4, 16);
    chk(rd_valid, 0);
  endtask

  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_single;
    t_wait;
    t_burst;
    t_cut;
    t_both;
    t_unburst;
    t_write;
    t_fill;
    t_fifo;
    complete_run;
  end
endmodule
